// File: inc/mtl_pkg.sv
// shared constants, register map and types for the multi-packet transfer and bus link command block
package mtl_pkg;
	// clock and timing
	localparam longint CLK_HZ          = 64'd10_000_000;
	localparam longint SECOND_CYCLES   = CLK_HZ;
	localparam longint GRACE_MINUTES   = 64'd4;
	localparam longint GRACE_CYCLES    = GRACE_MINUTES * 64'd60 * CLK_HZ;

	// register byte offsets
	localparam logic [7:0] OFF_CMD     = 8'h00;
	localparam logic [7:0] OFF_ARG     = 8'h04;
	localparam logic [7:0] OFF_LIMIT   = 8'h08;
	localparam logic [7:0] OFF_DATA    = 8'h0c;
	localparam logic [7:0] OFF_STATUS  = 8'h10;
	localparam logic [7:0] OFF_CONFIG  = 8'h14;
	localparam logic [7:0] OFF_MAP     = 8'h18;
	localparam logic [7:0] OFF_SLEEP   = 8'h1c;
	localparam logic [7:0] OFF_PROTO   = 8'h20;

	// transfer limits
	localparam logic [9:0]  TOTAL_MIN  = 10'd50;
	localparam logic [9:0]  TOTAL_LIM  = 10'd750;
	localparam logic [7:0]  PKT_MAX    = 8'd50;
	localparam int          MEM_DEPTH  = 750;
	localparam int          STAGE_DEPTH = 52;
	localparam int          SEQ_COUNT  = 256;

	// protocol slots 6 through f
	localparam logic [3:0]  SLOT_FIRST = 4'h6;
	localparam int          SLOT_COUNT = 10;
	localparam logic [2:0]  XCVR_SWITCH_ABOVE = 3'd3;
	localparam int          PRIV_COUNT = 8;

	// reset values
	localparam logic [1:0]  FC_MODE_RST = 2'd0;
	localparam logic [15:0] SLEEP_DUR_RST = 16'h0000;

	typedef enum logic [3:0] {
		OP_OPEN, OP_SEND, OP_CLOSE, OP_ABORT, OP_SHOW_MAP, OP_LINK_HS, OP_LINK_MS, OP_LINK_SW,
		OP_TERM, OP_XCVR, OP_WAKE_CAN, OP_WAKE_ISO, OP_WAKE_DELETE, OP_SELECT_STD, OP_SELECT_CUSTOM,
		OP_NONE
	} mtl_op_type;

	typedef enum logic [1:0] {IFACE_HS, IFACE_MS, IFACE_SW, IFACE_RSV} mtl_iface_type;
	typedef enum logic [1:0] {FAM_NONE, FAM_CAN, FAM_ISO, FAM_OTHER} mtl_family_type;
	typedef enum logic [1:0] {REPLY_NONE, REPLY_OK, REPLY_QUESTION, REPLY_RSV} mtl_reply_type;
	typedef enum logic [2:0] {WAKE_NONE, WAKE_PRIVATE, WAKE_TEMP, WAKE_LEGACY, WAKE_DEFAULT} mtl_wake_type;

	// command word written to the command register
	typedef struct packed {
		logic [21:0]    rsv;
		mtl_family_type fam;
		logic [3:0]     arg;
		mtl_op_type     op;
	} mtl_cmd_type;

	// open arguments
	typedef struct packed {
		logic [6:0] rsv1;
		logic       check_enable;
		logic [7:0] packet_size;
		logic [5:0] rsv0;
		logic [9:0] total_length;
	} mtl_arg_type;

	// request stream towards the vehicle bus
	typedef struct packed {
		logic       valid;
		logic       last;
		logic [7:0] data;
	} mtl_req_type;
endpackage : mtl_pkg

// File: src/mtl_cmd_core.sv
// command interpreter: multi-packet transfer channel, interface map, transceiver, wake priority, sleep, flow control
//
// Function
// - open refused with question mark while long-request mode is on
// - open refused when total length is below packet size
// - total length valid only from 50 up to but excluding 750
// - packet size above 50 is invalid
// - check enable of 1 makes every packet end in a checked sum byte
// - packet holds sequence byte, data, optional check; answered OK when good
// - check byte equals sum of data bytes, sequence byte excluded
// - close checks all packets arrived, closes, streams request; else question mark
// - optional close argument limits replies; none means unlimited until timeout
// - abort discards transfer and closes channel at any point, answering OK
// - slots 6 to f each keep an interface choice, shown on request
// - link commands assign high-speed, medium-speed or single-wire to one slot
// - termination switch connects for 1 and disconnects for 0
// - transceiver mode 0 to 7; above 3 also connects termination switch
// - wake sequence index 0 is temporary and cleared at reset
// - wake index 1 to 8 is private, active only under selected custom protocol
// - temporary wake setting ignored unless current protocol family matches command
// - private beats temporary; temporary beats legacy wake settings
// - standard select disables private; temporary else legacy else none for can, default iso
// - sleep duration condition ignored during first 4 minutes after reset
// - four flow-control modes 0 to 3, mode 0 after reset
// - mode 1 with extended address inserts that byte first in flow-control data
`timescale 1ns/1ps
module mtl_cmd_core
	import mtl_pkg::*;
#(
	parameter logic [31:0] GRACE_CNT  = 32'(GRACE_CYCLES),
	parameter logic [31:0] SECOND_CNT = 32'(SECOND_CYCLES)
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output mtl_req_type      req,
	input  wire logic        req_ready,
	output logic      [7:0]  req_reply_limit,
	output logic             req_reply_unlimited,
	output logic             term_switch,
	output logic      [1:0]  xcvr_mode,
	output mtl_wake_type     wake_source,
	input  wire logic        low_voltage,
	output logic             sleep_request,
	output logic      [1:0]  fc_mode,
	output logic             fc_insert_ext,
	output logic      [7:0]  fc_ext_byte
);
	typedef enum logic [1:0] {ST_IDLE, ST_COPY, ST_STREAM} mtl_state_type;

	// slot number range check, shared by the link reply and the map write
	function automatic logic slot_ok(input logic [3:0] s);
		slot_ok = (s >= SLOT_FIRST);
	endfunction : slot_ok

	mtl_state_type   state_r;
	mtl_reply_type   reply_r;
	mtl_arg_type     arg_r;
	logic [8:0]      limit_r;
	logic            long_req_r;
	logic [1:0]      fc_mode_r;
	logic            fc_ext_present_r;
	logic [7:0]      fc_ext_addr_r;
	logic            legacy_wake_r;
	logic [15:0]     sleep_dur_r;
	logic            open_r;
	logic [9:0]      tot_r;
	logic [7:0]      size_r;
	logic            chk_r;
	logic [9:0]      rx_bytes_r;
	logic [SEQ_COUNT-1:0] rx_bits_r;
	logic [7:0]      stage_r [STAGE_DEPTH];
	logic [5:0]      stage_cnt_r;
	logic            stage_ovf_r;
	logic [7:0]      stage_sum_r;
	logic [7:0]      stage_last_r;
	logic [7:0]      mem_r [MEM_DEPTH];
	logic [5:0]      copy_idx_r;
	logic [5:0]      copy_len_r;
	logic [9:0]      copy_base_r;
	logic [7:0]      copy_seq_r;
	logic [9:0]      stream_idx_r;
	logic [7:0]      req_data_r;
	logic            req_valid_r;
	mtl_iface_type   map_r [SLOT_COUNT];
	logic            term_r;
	logic [1:0]      xcvr_r;
	mtl_family_type  fam_r;
	logic [3:0]      custom_r;
	logic            temp_r;
	mtl_family_type  temp_fam_r;
	logic [PRIV_COUNT-1:0] priv_can_r;
	logic [PRIV_COUNT-1:0] priv_iso_r;
	mtl_wake_type    wake_r;
	logic [31:0]     grace_cnt_r;
	logic            grace_done_r;
	logic [31:0]     sec_cnt_r;
	logic [15:0]     low_secs_r;
	logic            sleep_r;

	// bus decode; the slave never waits
	wire logic       acc      = psel & penable;
	wire logic       wr       = acc & pwrite;
	wire logic       wr_cmd   = wr && (paddr == OFF_CMD);
	wire logic       wr_arg   = wr && (paddr == OFF_ARG);
	wire logic       wr_limit = wr && (paddr == OFF_LIMIT);
	wire logic       wr_data  = wr && (paddr == OFF_DATA);
	wire logic       wr_cfg   = wr && (paddr == OFF_CONFIG);
	wire logic       wr_sleep = wr && (paddr == OFF_SLEEP);
	wire mtl_cmd_type cmd     = mtl_cmd_type'(pwdata);
	wire logic       idle     = (state_r == ST_IDLE);

	// open checks on the staged arguments
	wire logic [9:0] a_tot    = arg_r.total_length;
	wire logic [7:0] a_size   = arg_r.packet_size;
	wire logic       len_ok   = (a_tot >= TOTAL_MIN) && (a_tot < TOTAL_LIM);
	wire logic       size_ok  = (a_size != 8'h00) && (a_size <= PKT_MAX);
	wire logic       open_ok  = !long_req_r && len_ok && size_ok && ({2'b00, a_size} <= a_tot);

	// packet checks on the staging buffer
	wire logic [5:0] pkt_len  = stage_cnt_r - 6'd1 - {5'd0, chk_r};
	wire logic [15:0] pkt_base = 16'(stage_r[0]) * 16'(size_r);
	wire logic [15:0] pkt_end = pkt_base + 16'(pkt_len);
	wire logic [7:0] data_sum = stage_sum_r - stage_last_r;
	wire logic       sum_ok   = !chk_r || (data_sum == stage_last_r);
	wire logic       pkt_ok   = !stage_ovf_r && (stage_cnt_r > (6'd1 + {5'd0, chk_r})) &&
		({2'b00, pkt_len} <= size_r) && (pkt_end <= 16'(tot_r)) && sum_ok;
	wire logic       copy_done = (state_r == ST_COPY) && (copy_idx_r == copy_len_r - 6'd1);
	wire logic       all_in   = (rx_bytes_r == tot_r);

	// request stream handshake and read-ahead
	wire logic       req_hs   = req_valid_r & req_ready;
	wire logic       req_last = (stream_idx_r == tot_r - 10'd1);
	wire logic       start_stream = wr_cmd && idle && (cmd.op == OP_CLOSE) && open_r && all_in;
	wire logic       stream_end = (state_r == ST_STREAM) && req_hs && req_last;
	wire logic       abort_now = wr_cmd && (cmd.op == OP_ABORT) && (open_r || !idle);
	wire logic [9:0] load_addr = start_stream ? 10'd0 : stream_idx_r + 10'd1;
	wire logic       load_en  = start_stream || ((state_r == ST_STREAM) && req_hs && !req_last);

	// command outcome for commands that answer at once
	mtl_reply_type   cmd_reply;
	always_comb begin
		cmd_reply = REPLY_QUESTION;
		if (!idle && cmd.op != OP_ABORT) begin
			cmd_reply = REPLY_QUESTION;
		end else begin
			case (cmd.op)
				OP_OPEN:          cmd_reply = open_ok ? REPLY_OK : REPLY_QUESTION;
				OP_SEND:          cmd_reply = REPLY_NONE;
				OP_CLOSE:         cmd_reply = (open_r && all_in) ? REPLY_NONE : REPLY_QUESTION;
				OP_ABORT:         cmd_reply = abort_now ? REPLY_OK : REPLY_QUESTION;
				OP_SHOW_MAP:      cmd_reply = REPLY_OK;
				OP_LINK_HS,
				OP_LINK_MS,
				OP_LINK_SW:       cmd_reply = slot_ok(cmd.arg) ? REPLY_OK : REPLY_QUESTION;
				OP_TERM:          cmd_reply = (cmd.arg <= 4'd1) ? REPLY_OK : REPLY_QUESTION;
				OP_XCVR:          cmd_reply = (cmd.arg <= 4'd7) ? REPLY_OK : REPLY_QUESTION;
				OP_WAKE_CAN:      cmd_reply = (cmd.arg > 4'd8 || (cmd.arg == 4'd0 && fam_r != FAM_CAN)) ?
					REPLY_QUESTION : REPLY_OK;
				OP_WAKE_ISO:      cmd_reply = (cmd.arg > 4'd8 || (cmd.arg == 4'd0 && fam_r != FAM_ISO)) ?
					REPLY_QUESTION : REPLY_OK;
				OP_WAKE_DELETE:   cmd_reply = (cmd.arg <= 4'd8) ? REPLY_OK : REPLY_QUESTION;
				OP_SELECT_STD:    cmd_reply = REPLY_OK;
				OP_SELECT_CUSTOM: cmd_reply = (cmd.arg >= 4'd1 && cmd.arg <= 4'd8) ? REPLY_OK : REPLY_QUESTION;
				default:          cmd_reply = REPLY_QUESTION;
			endcase
		end
	end

	// state machine for copy and stream phases
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
		end else if (abort_now) begin
			state_r <= ST_IDLE;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (wr_cmd && cmd.op == OP_SEND && open_r && pkt_ok) begin
						state_r <= ST_COPY;
					end else if (start_stream) begin
						state_r <= ST_STREAM;
					end
				end
				ST_COPY:   if (copy_done) state_r <= ST_IDLE;
				ST_STREAM: if (stream_end) state_r <= ST_IDLE;
				default:   state_r <= ST_IDLE;
			endcase
		end
	end

	// reply code: cleared by a new command, set when the outcome is known
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reply_r <= REPLY_NONE;
		end else if (wr_cmd) begin
			if (cmd.op == OP_SEND && idle) begin
				reply_r <= (open_r && pkt_ok) ? REPLY_NONE : REPLY_QUESTION;
			end else begin
				reply_r <= cmd_reply;
			end
		end else if (copy_done || stream_end) begin
			reply_r <= REPLY_OK;
		end
	end

	// software-written registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			arg_r            <= '0;
			limit_r          <= '0;
			long_req_r       <= 1'b0;
			fc_mode_r        <= FC_MODE_RST;
			fc_ext_present_r <= 1'b0;
			fc_ext_addr_r    <= 8'h00;
			legacy_wake_r    <= 1'b0;
			sleep_dur_r      <= SLEEP_DUR_RST;
		end else begin
			if (wr_arg) arg_r <= mtl_arg_type'(pwdata);
			if (wr_limit) limit_r <= pwdata[8:0];
			if (wr_sleep) sleep_dur_r <= pwdata[15:0];
			if (wr_cfg) begin
				long_req_r       <= pwdata[0];
				fc_mode_r        <= pwdata[2:1];
				fc_ext_present_r <= pwdata[3];
				legacy_wake_r    <= pwdata[4];
				fc_ext_addr_r    <= pwdata[15:8];
			end
		end
	end

	// channel bookkeeping
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			open_r     <= 1'b0;
			tot_r      <= '0;
			size_r     <= '0;
			chk_r      <= 1'b0;
			rx_bytes_r <= '0;
			rx_bits_r  <= '0;
		end else if (abort_now || start_stream) begin
			open_r <= 1'b0;
		end else if (wr_cmd && idle && cmd.op == OP_OPEN && open_ok) begin
			open_r     <= 1'b1;
			tot_r      <= a_tot;
			size_r     <= a_size;
			chk_r      <= arg_r.check_enable;
			rx_bytes_r <= '0;
			rx_bits_r  <= '0;
		end else if (copy_done && !rx_bits_r[copy_seq_r]) begin
			rx_bits_r[copy_seq_r] <= 1'b1;
			rx_bytes_r <= rx_bytes_r + {4'd0, copy_len_r};
		end
	end

	// staging buffer fills from data writes; sum excludes the sequence byte
	always_ff @(posedge clk) begin
		if (!rst_n || copy_done || abort_now || (wr_cmd && idle && cmd.op inside {OP_SEND, OP_OPEN} &&
			!(cmd.op == OP_SEND && open_r && pkt_ok))) begin
			stage_cnt_r  <= '0;
			stage_ovf_r  <= 1'b0;
			stage_sum_r  <= 8'h00;
			stage_last_r <= 8'h00;
		end else if (wr_data && idle) begin
			if (stage_cnt_r == 6'(STAGE_DEPTH)) begin
				stage_ovf_r <= 1'b1;
			end else begin
				stage_r[stage_cnt_r] <= pwdata[7:0];
				stage_cnt_r  <= stage_cnt_r + 6'd1;
				stage_last_r <= pwdata[7:0];
				if (stage_cnt_r != 6'd0) stage_sum_r <= stage_sum_r + pwdata[7:0];
			end
		end
	end

	// copy one byte per cycle into place; a resent packet overwrites its slot
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			copy_idx_r  <= '0;
			copy_len_r  <= '0;
			copy_base_r <= '0;
			copy_seq_r  <= '0;
		end else if (state_r == ST_IDLE) begin
			copy_idx_r  <= '0;
			copy_len_r  <= pkt_len;
			copy_base_r <= pkt_base[9:0];
			copy_seq_r  <= stage_r[0];
		end else if (state_r == ST_COPY) begin
			copy_idx_r <= copy_idx_r + 6'd1;
		end
	end

	always_ff @(posedge clk) begin
		if (state_r == ST_COPY) mem_r[copy_base_r + 10'(copy_idx_r)] <= stage_r[copy_idx_r + 6'd1];
	end

	// request stream out of the assembled buffer
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stream_idx_r        <= '0;
			req_valid_r         <= 1'b0;
			req_data_r          <= 8'h00;
			req_reply_limit     <= 8'h00;
			req_reply_unlimited <= 1'b1;
		end else begin
			if (load_en) req_data_r <= mem_r[load_addr];
			if (start_stream) begin
				stream_idx_r        <= '0;
				req_valid_r         <= 1'b1;
				req_reply_limit     <= limit_r[7:0];
				req_reply_unlimited <= !limit_r[8];
			end else if (abort_now || stream_end) begin
				req_valid_r <= 1'b0;
			end else if (load_en) begin
				stream_idx_r <= load_addr;
			end
		end
	end
	assign req = '{valid: req_valid_r, last: req_valid_r & req_last, data: req_data_r};

	// interface map per slot; reset pattern hs for 6..a, ms for b..e, sw for f
	for (genvar g = 0; g < SLOT_COUNT; g++) begin : g_slot
		localparam mtl_iface_type RST_SEL = (g < 5) ? IFACE_HS : ((g < 9) ? IFACE_MS : IFACE_SW);
		wire logic hit = wr_cmd && idle && slot_ok(cmd.arg) && (4'(cmd.arg - SLOT_FIRST) == 4'(g));
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				map_r[g] <= RST_SEL;
			end else if (hit && cmd.op == OP_LINK_HS) begin
				map_r[g] <= IFACE_HS;
			end else if (hit && cmd.op == OP_LINK_MS) begin
				map_r[g] <= IFACE_MS;
			end else if (hit && cmd.op == OP_LINK_SW) begin
				map_r[g] <= IFACE_SW;
			end
		end
	end

	// single-wire termination switch and transceiver mode
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			term_r <= 1'b0;
			xcvr_r <= 2'd0;
		end else if (wr_cmd && idle && cmd.op == OP_TERM && cmd.arg <= 4'd1) begin
			term_r <= cmd.arg[0];
		end else if (wr_cmd && idle && cmd.op == OP_XCVR && cmd.arg <= 4'd7) begin
			xcvr_r <= cmd.arg[1:0];
			if (cmd.arg[2:0] > XCVR_SWITCH_ABOVE) term_r <= 1'b1;
		end
	end

	// protocol selection and wake sequence bookkeeping
	wire logic       wake_cmd = wr_cmd && idle && (cmd.op == OP_WAKE_CAN || cmd.op == OP_WAKE_ISO);
	wire logic [2:0] widx     = 3'(cmd.arg - 4'd1);
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			fam_r      <= FAM_NONE;
			custom_r   <= 4'd0;
			temp_r     <= 1'b0;
			temp_fam_r <= FAM_NONE;
			priv_can_r <= '0;
			priv_iso_r <= '0;
		end else if (wr_cmd && idle && cmd.op == OP_SELECT_STD) begin
			fam_r    <= cmd.fam;
			custom_r <= 4'd0;
		end else if (wr_cmd && idle && cmd.op == OP_SELECT_CUSTOM && cmd_reply == REPLY_OK) begin
			fam_r    <= cmd.fam;
			custom_r <= cmd.arg;
		end else if (wake_cmd && cmd_reply == REPLY_OK) begin
			if (cmd.arg == 4'd0) begin
				temp_r     <= 1'b1;
				temp_fam_r <= fam_r;
			end else if (cmd.op == OP_WAKE_CAN) begin
				priv_can_r[widx] <= 1'b1;
			end else begin
				priv_iso_r[widx] <= 1'b1;
			end
		end else if (wr_cmd && idle && cmd.op == OP_WAKE_DELETE && cmd.arg <= 4'd8) begin
			if (cmd.arg == 4'd0) begin
				temp_r <= 1'b0;
			end else if (cmd.fam == FAM_ISO) begin
				priv_iso_r[widx] <= 1'b0;
			end else begin
				priv_can_r[widx] <= 1'b0;
			end
		end
	end

	// wake source priority: private, temporary, legacy, then family default
	wire logic [2:0] cidx     = 3'(custom_r - 4'd1);
	wire logic       priv_on  = (custom_r != 4'd0) &&
		((fam_r == FAM_CAN && priv_can_r[cidx]) || (fam_r == FAM_ISO && priv_iso_r[cidx]));
	wire logic       temp_on  = temp_r && (temp_fam_r == fam_r);
	wire mtl_wake_type wake_nxt = priv_on ? WAKE_PRIVATE :
		temp_on ? WAKE_TEMP :
		legacy_wake_r ? WAKE_LEGACY :
		(fam_r == FAM_ISO) ? WAKE_DEFAULT : WAKE_NONE;
	always_ff @(posedge clk) begin
		if (!rst_n) wake_r <= WAKE_NONE;
		else wake_r <= wake_nxt;
	end

	// low-voltage sleep with grace window after reset; the duration counts during it, only the request waits for its end
	wire logic sec_tick = (sec_cnt_r == SECOND_CNT - 32'd1);
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			grace_cnt_r  <= '0;
			grace_done_r <= 1'b0;
			sec_cnt_r    <= '0;
			low_secs_r   <= '0;
			sleep_r      <= 1'b0;
		end else begin
			if (!grace_done_r) grace_cnt_r <= grace_cnt_r + 32'd1;
			if (grace_cnt_r == GRACE_CNT - 32'd1) grace_done_r <= 1'b1;
			sec_cnt_r <= (sec_tick || !low_voltage) ? 32'd0 : sec_cnt_r + 32'd1;
			if (!low_voltage) low_secs_r <= '0;
			else if (sec_tick && low_secs_r != 16'hffff) low_secs_r <= low_secs_r + 16'd1;
			sleep_r <= grace_done_r && low_voltage && (sleep_dur_r != 16'h0000) &&
				(low_secs_r >= sleep_dur_r);
		end
	end

	// flow-control extended address insertion only in mode 1
	assign fc_mode       = fc_mode_r;
	assign fc_insert_ext = (fc_mode_r == 2'd1) && fc_ext_present_r;
	assign fc_ext_byte   = fc_insert_ext ? fc_ext_addr_r : 8'h00;

	assign term_switch   = term_r;
	assign xcvr_mode     = xcvr_r;
	assign wake_source   = wake_r;
	assign sleep_request = sleep_r;

	// read mux; unmapped addresses return zero with an error
	wire logic [19:0] map_flat = {map_r[9], map_r[8], map_r[7], map_r[6], map_r[5],
		map_r[4], map_r[3], map_r[2], map_r[1], map_r[0]};
	wire logic hit_any = paddr inside {OFF_CMD, OFF_ARG, OFF_LIMIT, OFF_DATA, OFF_STATUS,
		OFF_CONFIG, OFF_MAP, OFF_SLEEP, OFF_PROTO};
	assign pready  = 1'b1;
	assign pslverr = acc && !hit_any;
	assign prdata  = (paddr == OFF_ARG)    ? 32'(arg_r) :
		(paddr == OFF_LIMIT)  ? {23'd0, limit_r} :
		(paddr == OFF_STATUS) ? {23'd0, grace_done_r, sleep_r, wake_r, open_r, !idle, reply_r} :
		(paddr == OFF_CONFIG) ? {16'd0, fc_ext_addr_r, 3'd0, legacy_wake_r, fc_ext_present_r, fc_mode_r,
			long_req_r} :
		(paddr == OFF_MAP)    ? {12'd0, map_flat} :
		(paddr == OFF_SLEEP)  ? {16'd0, sleep_dur_r} :
		(paddr == OFF_PROTO)  ? {4'd0, xcvr_r, term_r, temp_r, priv_iso_r, priv_can_r, custom_r, 2'd0, fam_r} :
		32'h0000_0000;
endmodule : mtl_cmd_core

// File: verif/mtl_cmd_checker.sv
// assertions on the command interpreter ports
`timescale 1ns/1ps
module mtl_cmd_checker
	import mtl_pkg::*;
#(parameter logic [31:0] GRACE_CNT = 32'(GRACE_CYCLES)) (
	input logic        clk,
	input logic        rst_n,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [7:0]  paddr,
	input logic        pslverr,
	input mtl_req_type req,
	input logic        req_ready,
	input logic        term_switch,
	input logic [1:0]  xcvr_mode,
	input logic        sleep_request,
	input logic [1:0]  fc_mode,
	input logic        fc_insert_ext
);
	logic [31:0] up_cnt_r;
	wire acc_wr = psel && penable && pwrite;
	wire cmd_wr = acc_wr && paddr == OFF_CMD;
	// saturating age count, so sleep is judged against the grace time
	always_ff @(posedge clk) begin
		if (!rst_n) up_cnt_r <= '0;
		else if (up_cnt_r != GRACE_CNT) up_cnt_r <= up_cnt_r + 32'd1;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_err_phase: assert property (pslverr |-> psel && penable) else $error("late error");
	a_byte_held: assert property (req.valid && !req_ready && !acc_wr |=>
		req.valid && $stable(req.data)) else $error("byte lost");
	a_last_drop: assert property (req.valid && req.last && req_ready && !acc_wr |=> !req.valid)
		else $error("stream overrun");
	a_term_cause: assert property ($rose(term_switch) |-> $past(cmd_wr)) else $error("term");
	a_xcvr_cause: assert property ($past(rst_n) && $changed(xcvr_mode) |-> $past(cmd_wr))
		else $error("xcvr");
	a_fc_change: assert property ($past(rst_n) && $changed(fc_mode) |->
		$past(acc_wr && paddr == OFF_CONFIG)) else $error("fc mode");
	a_fc_insert: assert property (fc_insert_ext |-> fc_mode == 2'd1) else $error("fc ext");
	a_sleep_grace: assert property (sleep_request |-> up_cnt_r == GRACE_CNT) else $error("sleep");
	c_last: cover property (req.valid && req.last && req_ready);
	c_err: cover property (pslverr);
	c_sleep: cover property (sleep_request);
endmodule : mtl_cmd_checker
bind mtl_cmd_core mtl_cmd_checker #(.GRACE_CNT(GRACE_CNT)) i_chk (.*);

// File: verif/mtl_sink.sv
// vehicle-bus sink; stalls one cycle in three so held bytes get exercised
`timescale 1ns/1ps
module mtl_sink (
	input  logic clk,
	output logic req_ready = 1'b0
);
	always @(posedge clk) req_ready <= $urandom % 3 != 0;
endmodule : mtl_sink

// File: verif/tb.sv
// self-checking bench for the command interpreter
`timescale 1ns/1ps
module tb;
	import mtl_pkg::*;
	logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, low_voltage = 0;
	logic pready, pslverr, req_ready, req_reply_unlimited, term_switch, sleep_request, fc_insert_ext;
	logic [7:0] paddr = 0, req_reply_limit, fc_ext_byte, sum, byte_q[$], pkt[$];
	logic [31:0] pwdata = 0, prdata, r, bad_arg[3] = '{32'h000a0031, 32'h000a02ee, 32'h00330064};
	logic [1:0] xcvr_mode, fc_mode;
	logic [63:0] t, rd_q[$];
	mtl_req_type req;
	mtl_wake_type wake_source;
	int mismatches, n_compared;
	mtl_cmd_core #(.GRACE_CNT(32'd200), .SECOND_CNT(32'd10)) i_dut (.*);
	mtl_sink i_sink (.*);
	initial forever #50 clk = ~clk;
	task automatic finish_test;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : finish_test
	task automatic cmp(input logic [31:0] g, e);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask : cmp
	// one transfer; a non-zero mask notes the expected read value
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, m, e);
		int n;
		if (m != 0) rd_q.push_back({m, e});
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge clk) penable <= 1;
		n = 0;
		do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
		r = prdata;
		{psel, penable} <= 2'b00;
		@(posedge clk) if (n == 20) begin mismatches++; finish_test(); end
	endtask : apb
	// command, then poll until a reply shows, then a checked status read
	task automatic cmd(input logic [3:0] o, a, input logic [1:0] e);
		apb(1, OFF_CMD, {24'd0, a, o}, 0, 0);
		for (int n = 0; n < 300 && r[1:0] == 2'd0; n++) apb(0, OFF_STATUS, 0, 0, 0);
		apb(0, OFF_STATUS, 0, 3, {30'd0, e});
	endtask : cmd
	task automatic send(input logic [7:0] s);
		sum = s;
		apb(1, OFF_DATA, 0, 0, 0);
		foreach (pkt[i]) begin apb(1, OFF_DATA, {24'd0, pkt[i]}, 0, 0); sum += pkt[i]; end
		apb(1, OFF_DATA, {24'd0, sum}, 0, 0);
	endtask : send
	// takes the oldest note whenever a read completes, and the oldest expected byte whenever a request byte completes
	always @(posedge clk) begin
		if (psel && penable && !pwrite && rd_q.size() > 0) begin
			t = rd_q.pop_front();
			cmp(prdata & t[63:32], t[31:0]);
		end
		if (psel && penable) cmp({31'd0, pslverr}, {31'd0, paddr == 8'h40});
		if (rst_n && req.valid && req_ready) cmp({24'd0, req.data}, {24'd0, byte_q.pop_front()});
	end
	initial begin
		void'($urandom(32'h6c5c));
		repeat (50) pkt.push_back(8'($urandom));
		repeat (3) @(posedge clk);
		rst_n <= 1;
		@(posedge clk);
		apb(0, OFF_MAP, 0, '1, 32'h00095400);
		apb(0, 8'h40, 0, '1, 0);
		cmd(6, 8, 1);
		apb(0, OFF_MAP, 0, '1, 32'h00095410);
		cmd(1, 0, 2);
		apb(1, OFF_CONFIG, 1, 0, 0);
		apb(1, OFF_ARG, 32'h01320032, 0, 0);
		cmd(0, 0, 2);
		apb(1, OFF_CONFIG, 0, 0, 0);
		foreach (bad_arg[i]) begin apb(1, OFF_ARG, bad_arg[i], 0, 0); cmd(0, 0, 2); end
		apb(1, OFF_ARG, 32'h01320032, 0, 0);
		cmd(0, 0, 1);
		send(8'h01);
		cmd(1, 0, 2);
		send(0);
		cmd(1, 0, 1);
		foreach (pkt[i]) byte_q.push_back(pkt[i]);
		cmd(2, 0, 1);
		cmp({31'd0, req_reply_unlimited}, 32'd1);
		cmd(3, 0, 2);
		cmd(0, 0, 1);
		cmd(3, 0, 1);
		cmd(2, 0, 2);
		cmd(8, 1, 1);
		cmd(8, 0, 1);
		cmd(9, 5, 1);
		cmp({29'd0, term_switch, xcvr_mode}, 32'h5);
		apb(0, OFF_PROTO, 0, 32'h0e000000, 32'h06000000);
		apb(1, OFF_CONFIG, 32'h4b0a, 0, 0);
		apb(0, OFF_CONFIG, 0, '1, 32'h4b0a);
		cmp({21'd0, fc_insert_ext, fc_ext_byte, fc_mode}, 32'h52d);
		// duration kept above 1000 seconds, as the host is advised
		apb(1, OFF_SLEEP, 32'd1001, 0, 0);
		low_voltage <= 1;
		repeat (5000) @(posedge clk);
		apb(0, OFF_STATUS, 0, 32'h180, 32'h100);
		repeat (5200) @(posedge clk);
		apb(0, OFF_STATUS, 0, 32'h180, 32'h180);
		finish_test();
	end
endmodule : tb
